// ===== mhhd_decode.sv
// upper-half second-accumulator multiply decoder, registered outputs
`timescale 1ns/100ps
module mhhd_decode (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic instrValid,
    input wire logic [31:0] instrWord,
    output logic hitValid_q,
    output mhhd_pkg::mhhd_op_type accOp_q,
    output mhhd_pkg::mhhd_opt_type option_q,
    output logic mixedMode_q,
    output logic parallelIssue_q,
    output mhhd_pkg::mhhd_half_type halfSel_q,
    output logic [2:0] upperHalfTarget_q,
    output logic [2:0] srcReg0_q,
    output logic [2:0] srcReg1_q
);
    import mhhd_pkg::*;

    logic [31:0] wordNorm;
    logic parallelHit;
    logic [15:0] upperHalf;
    logic [15:0] lowHalf;
    mhhd_half_type halfSel;
    logic [2:0] destReg;
    logic [2:0] srcReg0;
    logic [2:0] srcReg1;
    logic lowValid;
    logic upperValid;
    mhhd_opt_type optDecoded;
    logic optLegal;
    mhhd_op_type opDecoded;
    logic hit_d;

    assign parallelHit = instrWord[27];
    assign wordNorm = parallelHit ? (instrWord - PARALLEL_OFFSET) : instrWord;
    assign upperHalf = wordNorm[31:16];
    assign lowHalf = wordNorm[15:0];

    mhhd_field_split u_split (
        .lowHalf(lowHalf),
        .halfSel(halfSel),
        .destReg(destReg),
        .srcReg0(srcReg0),
        .srcReg1(srcReg1),
        .lowValid(lowValid)
    );

    assign upperValid = (upperHalf & UPPER_FIXED_MASK) == UPPER_FIXED_VAL;
    assign optDecoded = mhhd_opt_type'(upperHalf[OPT_LSB +: 4]);

    always_comb begin
        case (upperHalf[1:0])
            2'h0: opDecoded = MHHD_OP_ASSIGN;
            2'h1: opDecoded = MHHD_OP_ADD;
            2'h2: opDecoded = MHHD_OP_SUB;
            default: opDecoded = MHHD_OP_NONE;
        endcase
    end

    always_comb begin
        case (optDecoded)
            MHHD_OPT_DEFAULT, MHHD_OPT_INTEGER_HIGH_WORD, MHHD_OPT_TRUNC_FRACTION_UNSIGNED,
            MHHD_OPT_INTEGER_UNSIGNED, MHHD_OPT_FRACTION_UNSIGNED, MHHD_OPT_TRUNCATE,
            MHHD_OPT_INTEGER_SIGNED, MHHD_OPT_SCALED_ROUND_X2, MHHD_OPT_INTEGER_SIGNED_SCALED_X2,
            MHHD_OPT_INTEGER_UNSIGNED_ALT: optLegal = 1'b1;
            default: optLegal = 1'b0;
        endcase
    end

    assign hit_d = instrValid && upperValid && lowValid && optLegal && (opDecoded != MHHD_OP_NONE)
        && (instrWord[31:28] == 4'hc) && (instrWord[26:25] == 2'h0);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hitValid_q <= 1'b0;
        end else begin
            hitValid_q <= hit_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            accOp_q <= MHHD_OP_NONE;
            option_q <= MHHD_OPT_DEFAULT;
            mixedMode_q <= 1'b0;
            parallelIssue_q <= 1'b0;
            halfSel_q <= MHHD_HALF_LO_LO;
            upperHalfTarget_q <= 3'h0;
            srcReg0_q <= 3'h0;
            srcReg1_q <= 3'h0;
        end else if (hit_d) begin
            accOp_q <= opDecoded;
            option_q <= optDecoded;
            mixedMode_q <= upperHalf[MIXED_BIT];
            parallelIssue_q <= parallelHit;
            halfSel_q <= halfSel;
            upperHalfTarget_q <= destReg;
            srcReg0_q <= srcReg0;
            srcReg1_q <= srcReg1;
        end
    end

    property p_trunc;
        @(posedge clk) disable iff (!rst_n)
        (instrValid && instrWord == 32'hc0441800) |=> (hitValid_q && accOp_q == MHHD_OP_ASSIGN && option_q == MHHD_OPT_TRUNCATE);
    endproperty
    a_trunc: assert property (p_trunc) else $error("truncate assign not decoded");

    property p_add;
        @(posedge clk) disable iff (!rst_n)
        (instrValid && instrWord[31:16] == 16'hc185 && instrWord[15:0] == 16'h1800) |=> (hitValid_q && accOp_q == MHHD_OP_ADD);
    endproperty
    a_add: assert property (p_add) else $error("add accumulate not decoded");

    property p_sub;
        @(posedge clk) disable iff (!rst_n)
        (instrValid && instrWord == 32'hc1061800) |=> (hitValid_q && accOp_q == MHHD_OP_SUB && option_q == MHHD_OPT_INTEGER_SIGNED);
    endproperty
    a_sub: assert property (p_sub) else $error("subtract accumulate not decoded");

    property p_mixed;
        @(posedge clk) disable iff (!rst_n)
        (instrValid && instrWord == 32'hc1341800) |=> (hitValid_q && mixedMode_q
            && option_q == MHHD_OPT_INTEGER_SIGNED_SCALED_X2);
    endproperty
    a_mixed: assert property (p_mixed) else $error("mixed flag wrong");

    property p_ihm;
        @(posedge clk) disable iff (!rst_n)
        (instrValid && instrWord == 32'hc174d9ff) |=> (hitValid_q && mixedMode_q && accOp_q == MHHD_OP_ASSIGN
            && option_q == MHHD_OPT_INTEGER_HIGH_WORD);
    endproperty
    a_ihm: assert property (p_ihm) else $error("high word mixed not decoded");

    property p_par;
        @(posedge clk) disable iff (!rst_n)
        (instrValid && instrWord == 32'hc8051800) |=> (hitValid_q && parallelIssue_q && accOp_q == MHHD_OP_ADD);
    endproperty
    a_par: assert property (p_par) else $error("parallel form rejected");

    property p_fields;
        @(posedge clk) disable iff (!rst_n)
        hit_d |=> (halfSel_q == $past(halfSel) && upperHalfTarget_q == $past(lowHalf[8:6])
            && srcReg0_q == $past(lowHalf[5:3]) && srcReg1_q == $past(lowHalf[2:0]));
    endproperty
    a_fields: assert property (p_fields) else $error("register fields not forwarded");

    property p_range;
        @(posedge clk) disable iff (!rst_n)
        (instrValid && instrWord == 32'hc0041700) |=> !hitValid_q;
    endproperty
    a_range: assert property (p_range) else $error("out of range low half accepted");

    property p_op_reserved;
        @(posedge clk) disable iff (!rst_n)
        (instrValid && instrWord[17:16] == 2'h3) |=> !hitValid_q;
    endproperty
    a_op_reserved: assert property (p_op_reserved) else $error("reserved operation accepted");

    property p_idle;
        @(posedge clk) disable iff (!rst_n)
        !instrValid |=> !hitValid_q;
    endproperty
    a_idle: assert property (p_idle) else $error("hit without a valid word");

    property p_hold;
        @(posedge clk) disable iff (!rst_n)
        !hit_d |=> ($stable(accOp_q) && $stable(option_q) && $stable(mixedMode_q) && $stable(parallelIssue_q)
            && $stable(halfSel_q) && $stable(upperHalfTarget_q) && $stable(srcReg0_q) && $stable(srcReg1_q));
    endproperty
    a_hold: assert property (p_hold) else $error("forwarded fields changed without a hit");

    property p_tfu;
        @(posedge clk) disable iff (!rst_n)
        (instrValid && instrWord == 32'hc0c41800) |=> (hitValid_q && accOp_q == MHHD_OP_ASSIGN
            && option_q == MHHD_OPT_TRUNC_FRACTION_UNSIGNED && !mixedMode_q);
    endproperty
    a_tfu: assert property (p_tfu) else $error("truncated unsigned assign not decoded");

    property p_low_limit;
        @(posedge clk) disable iff (!rst_n)
        (instrValid && instrWord == 32'hc004da00) |=> !hitValid_q;
    endproperty
    a_low_limit: assert property (p_low_limit) else $error("low half past upper bound accepted");

    property p_hi_hi;
        @(posedge clk) disable iff (!rst_n)
        (instrValid && instrWord == 32'hc044d9ff) |=> (hitValid_q && halfSel_q == MHHD_HALF_HI_HI
            && upperHalfTarget_q == 3'h7 && srcReg0_q == 3'h7 && srcReg1_q == 3'h7);
    endproperty
    a_hi_hi: assert property (p_hi_hi) else $error("half select or register numbers wrong");

    property p_par_sub;
        @(posedge clk) disable iff (!rst_n)
        (instrValid && instrWord == 32'hc9061800) |=> (hitValid_q && parallelIssue_q && accOp_q == MHHD_OP_SUB
            && option_q == MHHD_OPT_INTEGER_SIGNED);
    endproperty
    a_par_sub: assert property (p_par_sub) else $error("parallel subtract form rejected");

    property p_add_fu;
        @(posedge clk) disable iff (!rst_n)
        (instrValid && instrWord == 32'hc0851800) |=> (hitValid_q && accOp_q == MHHD_OP_ADD
            && option_q == MHHD_OPT_FRACTION_UNSIGNED);
    endproperty
    a_add_fu: assert property (p_add_fu) else $error("fraction unsigned add not decoded");
endmodule : mhhd_decode

// ===== mhhd_pkg.sv
// shared constants and types for the upper-half multiply decoder
package mhhd_pkg;
    localparam logic [15:0] UPPER_BASE = 16'hc004;
    localparam logic [15:0] UPPER_FIXED_MASK = 16'hfe0c;
    localparam logic [15:0] UPPER_FIXED_VAL = 16'hc004;
    localparam logic [31:0] PARALLEL_OFFSET = 32'h08000000;
    localparam logic [15:0] LOW_MIN = 16'h1800;
    localparam logic [15:0] LOW_MAX = 16'hd9ff;
    localparam logic [15:0] LOW_FIXED_MASK = 16'h3e00;
    localparam logic [15:0] LOW_FIXED_VAL = 16'h1800;
    localparam int MIXED_BIT = 4;
    localparam int OP_LSB = 0;
    localparam int OPT_LSB = 5;
    localparam int HALF_LSB = 14;
    localparam int DEST_LSB = 6;
    localparam int SRC0_LSB = 3;
    localparam int SRC1_LSB = 0;
    localparam int LATENCY_CYCLES = 1;

    typedef enum logic [2:0] {
        MHHD_OP_NONE = 3'h0,
        MHHD_OP_ASSIGN = 3'h4,
        MHHD_OP_ADD = 3'h5,
        MHHD_OP_SUB = 3'h6
    } mhhd_op_type;

    // option field in upper halfword bits 8..5
    typedef enum logic [3:0] {
        MHHD_OPT_DEFAULT = 4'h0,
        MHHD_OPT_SCALED_ROUND_X2 = 4'h1,
        MHHD_OPT_TRUNCATE = 4'h2,
        MHHD_OPT_INTEGER_UNSIGNED_ALT = 4'h3,
        MHHD_OPT_FRACTION_UNSIGNED = 4'h4,
        MHHD_OPT_TRUNC_FRACTION_UNSIGNED = 4'h6,
        MHHD_OPT_INTEGER_SIGNED = 4'h8,
        MHHD_OPT_INTEGER_SIGNED_SCALED_X2 = 4'h9,
        MHHD_OPT_INTEGER_HIGH_WORD = 4'hb,
        MHHD_OPT_INTEGER_UNSIGNED = 4'hc
    } mhhd_opt_type;

    typedef enum logic [1:0] {
        MHHD_HALF_LO_LO = 2'h0,
        MHHD_HALF_LO_HI = 2'h1,
        MHHD_HALF_HI_LO = 2'h2,
        MHHD_HALF_HI_HI = 2'h3
    } mhhd_half_type;
endpackage : mhhd_pkg

// ===== mhhd_field_split.sv
// combinational split of the low halfword into register fields
`timescale 1ns/100ps
module mhhd_field_split (
    input wire logic [15:0] lowHalf,
    output mhhd_pkg::mhhd_half_type halfSel,
    output logic [2:0] destReg,
    output logic [2:0] srcReg0,
    output logic [2:0] srcReg1,
    output logic lowValid
);
    import mhhd_pkg::*;

    assign halfSel = mhhd_half_type'(lowHalf[HALF_LSB +: 2]);
    assign destReg = lowHalf[DEST_LSB +: 3];
    assign srcReg0 = lowHalf[SRC0_LSB +: 3];
    assign srcReg1 = lowHalf[SRC1_LSB +: 3];
    assign lowValid = ((lowHalf & LOW_FIXED_MASK) == LOW_FIXED_VAL) && (lowHalf >= LOW_MIN) && (lowHalf <= LOW_MAX);
endmodule : mhhd_field_split

// ===== mhhd_fetch_model.sv
// instruction fetch source model feeding the decoder
`timescale 1ns/100ps
module mhhd_fetch_model (
    input wire logic reqValid,
    input wire logic reqPar,
    input wire logic [31:0] reqWord,
    output logic instrValid,
    output logic [31:0] instrWord
);
    import mhhd_pkg::*;
    logic [31:0] heldWord = 32'h0;
    logic [31:0] liveWord;
    assign liveWord = reqWord + (reqPar ? PARALLEL_OFFSET : 32'h0);
    always @(reqValid or liveWord) begin
        if (reqValid) heldWord = liveWord;
    end
    assign instrValid = reqValid;
    // idle bus shows inverse of last word
    assign instrWord = reqValid ? liveWord : ~heldWord;
endmodule : mhhd_fetch_model

// ===== mhhd_decode_tb.sv
// self-checking bench for the upper-half multiply decoder
`timescale 1ns/100ps
module mhhd_decode_tb;
    import mhhd_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic reqValid = 1'b0;
    logic reqPar = 1'b0;
    logic [31:0] reqWord = 32'h0;
    logic instrValid, hitValid_q, mixedMode_q, parallelIssue_q;
    logic [31:0] instrWord;
    mhhd_op_type accOp_q;
    mhhd_opt_type option_q;
    mhhd_half_type halfSel_q;
    logic [2:0] upperHalfTarget_q, srcReg0_q, srcReg1_q;
    logic [15:0] eLow = 16'h0;
    int errors = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [3:0] opts [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'h9, 4'hb, 4'hc};
    logic [31:0] corners [13] = '{32'hc0441800, 32'hc044d9ff, 32'hc0c41800, 32'hc0051800, 32'hc1851800,
        32'hc1061800, 32'hc0941800, 32'hc1341800, 32'hc174d9ff, 32'hc0071800, 32'hc004da00,
        32'hc0041700, 32'hc0851800};
    mhhd_fetch_model u_src (.reqValid(reqValid), .reqPar(reqPar), .reqWord(reqWord),
        .instrValid(instrValid), .instrWord(instrWord));
    mhhd_decode u_dut (.clk(clk), .rst_n(rst_n), .instrValid(instrValid), .instrWord(instrWord),
        .hitValid_q(hitValid_q), .accOp_q(accOp_q), .option_q(option_q), .mixedMode_q(mixedMode_q),
        .parallelIssue_q(parallelIssue_q), .halfSel_q(halfSel_q), .upperHalfTarget_q(upperHalfTarget_q),
        .srcReg0_q(srcReg0_q), .srcReg1_q(srcReg1_q));
    initial forever #20 clk = ~clk;
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic fields;
        chk("half", 8'(eLow[15:14]), 8'(halfSel_q));
        chk("dest", 8'(eLow[8:6]), 8'(upperHalfTarget_q));
        chk("src", {2'h0, eLow[5:0]}, {2'h0, srcReg0_q, srcReg1_q});
    endtask : fields
    // word the decoder should see once the parallel offset is taken off
    function automatic logic [31:0] norm_word(input logic [31:0] b, input logic p);
        logic [31:0] w;
        w = b + (p ? PARALLEL_OFFSET : 32'h0);
        return w[27] ? w - PARALLEL_OFFSET : w;
    endfunction : norm_word
    function automatic logic exp_hit(input logic [31:0] w);
        logic optOk;
        optOk = 1'b0;
        foreach (opts[i]) if (opts[i] == w[24:21]) optOk = 1'b1;
        return optOk && ((w[31:16] & UPPER_FIXED_MASK) == UPPER_FIXED_VAL) && (w[17:16] != 2'h3)
            && ((w[15:0] & LOW_FIXED_MASK) == LOW_FIXED_VAL);
    endfunction : exp_hit
    task automatic send(input logic [31:0] b, input logic p);
        logic [31:0] w;
        logic h;
        w = norm_word(b, p);
        h = exp_hit(w);
        reqWord = b;
        reqPar = p;
        reqValid = 1'b1;
        @(posedge clk);
        #1;
        chk("hit", 8'(h), 8'(hitValid_q));
        if (h) begin
            eLow = w[15:0];
            chk("op", 8'(w[18:16]), 8'(accOp_q));
            chk("opt", 8'(w[24:21]), 8'(option_q));
            chk("mix", 8'(w[20]), 8'(mixedMode_q));
            chk("par", 8'(p), 8'(parallelIssue_q));
        end
        fields();
    endtask : send
    task automatic idle;
        reqValid = 1'b0;
        @(posedge clk);
        #1;
        chk("idle", 8'h0, 8'(hitValid_q));
    endtask : idle
    task tally_and_finish;
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    always @(posedge clk) begin
        cyc++;
        if (cyc > 4000) begin
            errors++;
            tally_and_finish();
        end
    end
    initial begin
        void'($urandom(32'h8526583f));
        repeat (6) @(posedge clk);
        #1;
        fields();
        rst_n = 1'b1;
        idle();
        for (int p = 0; p < 2; p++) foreach (corners[i]) send(corners[i], 1'(p));
        idle();
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        eLow = 16'h0;
        chk("rst op opt mix", 8'h0, {accOp_q, option_q, mixedMode_q});
        chk("rst hit par", 8'h0, 8'({hitValid_q, parallelIssue_q}));
        fields();
        rst_n = 1'b1;
        idle();
        repeat (1500) begin
            if ($urandom % 8 == 0) idle();
            else if ($urandom % 8 == 0) send($urandom & 32'h7fffffff, 1'($urandom));
            else send({7'h60, opts[$urandom % 10], 1'($urandom), 2'h1, 2'($urandom % 3),
                2'($urandom), 5'h0c, 9'($urandom)}, 1'($urandom));
        end
        tally_and_finish();
    end
endmodule : mhhd_decode_tb
